// ===== rtl/dma_chain_pkg.sv
package dma_chain_pkg;
	// ==================== sizes
	localparam int unsigned CW    = 16;
	localparam int unsigned AB    = 3;
	localparam int unsigned CNT_W = AB + 1;
	localparam int unsigned EVW   = 5;
	localparam logic [CNT_W-1:0] DEPTH_CNT  = 4'h8;
	localparam logic [CW-1:0]    ONE_CW     = 16'h0001;
	localparam logic [31:0]      ELEM_BYTES = 32'h0000_0004;
	localparam logic [3:0]       BE_ALL     = 4'hF;
	// ==================== register offsets
	localparam logic [7:0] OFS_CCR = 8'h00;
	localparam logic [7:0] OFS_SDP = 8'h04;
	localparam logic [7:0] OFS_CEN = 8'h08;
	localparam logic [7:0] OFS_CFN = 8'h0C;
	localparam logic [7:0] OFS_CSR = 8'h10;
	localparam logic [7:0] OFS_CLR = 8'h14;
	localparam logic [7:0] OFS_IEN = 8'h18;
	localparam logic [7:0] OFS_SRC = 8'h1C;
	localparam logic [7:0] OFS_DST = 8'h20;
	// ==================== field positions
	localparam int unsigned CCR_SYNC_LO = 0;
	localparam int unsigned SYNC_LO_W   = 5;
	localparam int unsigned CCR_EN      = 7;
	localparam int unsigned CCR_PAUSE   = 8;
	localparam int unsigned CCR_LINK    = 15;
	localparam int unsigned CCR_SYNC_HI = 19;
	localparam int unsigned SYNC_HI_W   = 2;
	localparam int unsigned CCR_PREF    = 23;
	localparam int unsigned CCR_SIDE    = 24;
	localparam int unsigned CCR_NOBUF   = 25;
	localparam int unsigned SDP_BURST   = 14;
	localparam int unsigned EV_DONE     = 0;
	localparam int unsigned EV_RDERR    = 1;
	localparam int unsigned EV_WRERR    = 2;
	localparam int unsigned EV_ABORT    = 3;
	localparam int unsigned EV_MISAL    = 4;
	localparam int unsigned CSR_EN      = 7;
	localparam int unsigned CSR_BUSY    = 15;
	localparam logic [1:0]  RESP_OK     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	// ==================== types
	typedef enum logic [1:0] {
		CH_IDLE  = 2'b00,
		CH_RUN   = 2'b01,
		CH_DRAIN = 2'b10,
		CH_ABORT = 2'b11
	} ch_state_t;
	typedef struct packed { logic [31:0] addr; } rd_req_t;
	typedef struct packed { logic [31:0] data; logic err; } rd_rsp_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
		logic        burst;
	} wr_req_t;
	typedef struct packed {
		ch_state_t            st;
		logic [31:0]          ccr, sdp, src, dst, rd_a, wr_a;
		logic [CW-1:0]        cen, cfn, rd_e, rd_f, wr_e, wr_f;
		logic [EVW-1:0]       sts, ien;
		logic                 rd_v, rd_w, wr_v, wr_w, pend, open, link;
		wr_req_t              wr_q;
		logic [CNT_W-1:0]     cnt;
		logic [AB-1:0]        wp, rp;
		logic [2:0]           rq;
	} ch_t;
	typedef struct packed {
		logic        awv, wv, bv, rv;
		logic [7:0]  awa;
		logic [31:0] wd, rd;
		logic [3:0]  ws;
		logic [1:0]  br, rr;
	} bus_t;
	localparam ch_t  CH_RST  = '0;
	localparam bus_t BUS_RST = '0;
endpackage

// ===== rtl/dma_word_buf.sv
`timescale 1ns/1ps
module dma_word_buf (
	input  wire logic                         mclk_i,
	input  wire logic                         we_i,
	input  wire logic [dma_chain_pkg::AB-1:0] waddr_i,
	input  wire logic [31:0]                  wdata_i,
	input  wire logic [dma_chain_pkg::AB-1:0] raddr_i,
	output logic      [31:0]                  rdata_o
);
	// ==================== storage
	logic [31:0] mem [2**dma_chain_pkg::AB];

	// write-through so a word pushed into an empty buffer is visible at once
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
	end
endmodule

// ===== rtl/dma_chain_channel.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module dma_chain_channel (
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     awvalid_i,
	output logic                          awready_o,
	input  wire logic [7:0]               awaddr_i,
	input  wire logic                     wvalid_i,
	output logic                          wready_o,
	input  wire logic [31:0]              wdata_i,
	input  wire logic [3:0]               wstrb_i,
	output logic                          bvalid_o,
	input  wire logic                     bready_i,
	output logic [1:0]                    bresp_o,
	input  wire logic                     arvalid_i,
	output logic                          arready_o,
	input  wire logic [7:0]               araddr_i,
	output logic                          rvalid_o,
	input  wire logic                     rready_i,
	output logic [31:0]                   rdata_o,
	output logic [1:0]                    rresp_o,
	input  wire logic                     peripheral_request_i,
	input  wire logic                     link_enable_i,
	output logic                          link_o,
	output logic                          rd_valid_o,
	input  wire logic                     rd_ready_i,
	output dma_chain_pkg::rd_req_t        rd_req_o,
	input  wire logic                     rd_rsp_valid_i,
	input  wire dma_chain_pkg::rd_rsp_t   rd_rsp_i,
	output logic                          wr_valid_o,
	input  wire logic                     wr_ready_i,
	output dma_chain_pkg::wr_req_t        wr_req_o,
	input  wire logic                     wr_rsp_valid_i,
	input  wire logic                     wr_rsp_err_i,
	output logic                          irq_o
);
	// ==================== helpers
	function automatic logic [2*dma_chain_pkg::CW-1:0] step(
		input logic [dma_chain_pkg::CW-1:0] e,
		input logic [dma_chain_pkg::CW-1:0] f,
		input logic [dma_chain_pkg::CW-1:0] n);
		if (e + dma_chain_pkg::ONE_CW == n) begin
			return {{dma_chain_pkg::CW{1'b0}}, f + dma_chain_pkg::ONE_CW};
		end
		return {e + dma_chain_pkg::ONE_CW, f};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ==================== state
	dma_chain_pkg::ch_t                 c_reg, c_next;
	dma_chain_pkg::bus_t                b_reg, b_next;
	logic [31:0]                        buf_rdata, wv, csr_word;
	logic [2*dma_chain_pkg::CW-1:0]     rstep, wstep;
	logic [dma_chain_pkg::EVW-1:0]      set_ev, clr_ev;
	logic                               sw_sync, src_side, pause, drain_cand, rd_all, wr_all;
	logic                               rd_gate, wr_gate, rise, w_last, sw_off, start;
	logic                               push, pop;

	// software sync when both fields zero
	assign sw_sync    = c_reg.ccr[dma_chain_pkg::CCR_SYNC_LO +: dma_chain_pkg::SYNC_LO_W] == '0
		&& c_reg.ccr[dma_chain_pkg::CCR_SYNC_HI +: dma_chain_pkg::SYNC_HI_W] == '0;
	assign src_side   = c_reg.ccr[dma_chain_pkg::CCR_SIDE];
	assign pause      = c_reg.ccr[dma_chain_pkg::CCR_PAUSE];
	assign drain_cand = !sw_sync && src_side && !c_reg.ccr[dma_chain_pkg::CCR_NOBUF];
	assign rd_all     = c_reg.rd_f == c_reg.cfn;
	assign wr_all     = c_reg.wr_f == c_reg.cfn;
	// destination sync with read-ahead lets reads run before the request
	assign rd_gate    = sw_sync || (src_side ? c_reg.open
		: (c_reg.ccr[dma_chain_pkg::CCR_PREF] || c_reg.open));
	assign wr_gate    = sw_sync || src_side || c_reg.open;
	assign rise       = c_reg.rq[1] && !c_reg.rq[2];
	assign rstep      = step(c_reg.rd_e, c_reg.rd_f, c_reg.cen);
	assign wstep      = step(c_reg.wr_e, c_reg.wr_f, c_reg.cen);
	assign w_last     = wstep[dma_chain_pkg::CW-1:0] == c_reg.cfn;

	dma_word_buf u_buf (
		.mclk_i  (mclk_i),
		.we_i    (push),
		.waddr_i (c_reg.wp),
		.wdata_i (rd_rsp_i.data),
		.raddr_i (c_next.rp),
		.rdata_o (buf_rdata)
	);

	// ==================== next state
	always_comb begin
		c_next   = c_reg;
		b_next   = b_reg;
		set_ev   = '0;
		clr_ev   = '0;
		push     = 1'b0;
		pop      = 1'b0;
		start    = 1'b0;
		c_next.link = 1'b0;
		c_next.rq   = {c_reg.rq[1:0], peripheral_request_i};
		wv       = merge(32'h0000_0000, b_reg.wd, b_reg.ws);
		csr_word = '0;
		csr_word[dma_chain_pkg::EVW-1:0]  = c_reg.sts;
		csr_word[dma_chain_pkg::CSR_EN]   = c_reg.ccr[dma_chain_pkg::CCR_EN];
		csr_word[dma_chain_pkg::CSR_BUSY] = c_reg.st != dma_chain_pkg::CH_IDLE;
		// bus writes: address and data may arrive in either order
		if (awvalid_i && awready_o) begin
			b_next.awv = 1'b1;
			b_next.awa = awaddr_i;
		end
		if (wvalid_i && wready_o) begin
			b_next.wv = 1'b1;
			b_next.wd = wdata_i;
			b_next.ws = wstrb_i;
		end
		if (b_reg.bv && bready_i) begin
			b_next.bv = 1'b0;
		end
		if (b_reg.awv && b_reg.wv && !b_reg.bv) begin
			b_next.awv = 1'b0;
			b_next.wv  = 1'b0;
			b_next.bv  = 1'b1;
			b_next.br  = dma_chain_pkg::RESP_OK;
			unique case (b_reg.awa)
				dma_chain_pkg::OFS_CCR: c_next.ccr = merge(c_reg.ccr, b_reg.wd, b_reg.ws);
				dma_chain_pkg::OFS_SDP: c_next.sdp = merge(c_reg.sdp, b_reg.wd, b_reg.ws);
				dma_chain_pkg::OFS_CEN: c_next.cen = wv[dma_chain_pkg::CW-1:0];
				dma_chain_pkg::OFS_CFN: c_next.cfn = wv[dma_chain_pkg::CW-1:0];
				dma_chain_pkg::OFS_CSR: ;
				dma_chain_pkg::OFS_CLR: clr_ev = wv[dma_chain_pkg::EVW-1:0];
				dma_chain_pkg::OFS_IEN: c_next.ien = wv[dma_chain_pkg::EVW-1:0];
				dma_chain_pkg::OFS_SRC: c_next.src = merge(c_reg.src, b_reg.wd, b_reg.ws);
				dma_chain_pkg::OFS_DST: c_next.dst = merge(c_reg.dst, b_reg.wd, b_reg.ws);
				default:                b_next.br  = dma_chain_pkg::RESP_SLVERR;
			endcase
		end
		if (b_reg.rv && rready_i) begin
			b_next.rv = 1'b0;
		end
		if (arvalid_i && arready_o) begin
			b_next.rv = 1'b1;
			b_next.rr = dma_chain_pkg::RESP_OK;
			unique case (araddr_i)
				dma_chain_pkg::OFS_CCR: b_next.rd = c_reg.ccr;
				dma_chain_pkg::OFS_SDP: b_next.rd = c_reg.sdp;
				dma_chain_pkg::OFS_CEN: b_next.rd = {16'h0000, c_reg.cen};
				dma_chain_pkg::OFS_CFN: b_next.rd = {16'h0000, c_reg.cfn};
				dma_chain_pkg::OFS_CSR: b_next.rd = csr_word;
				dma_chain_pkg::OFS_CLR: b_next.rd = 32'h0000_0000;
				dma_chain_pkg::OFS_IEN: b_next.rd = {27'h0000000, c_reg.ien};
				dma_chain_pkg::OFS_SRC: b_next.rd = c_reg.src;
				dma_chain_pkg::OFS_DST: b_next.rd = c_reg.dst;
				default: begin
					b_next.rd = 32'h0000_0000;
					b_next.rr = dma_chain_pkg::RESP_SLVERR;
				end
			endcase
		end
		// request pulses become one frame credit at a time
		if (!c_reg.open && c_reg.pend && c_reg.st != dma_chain_pkg::CH_IDLE) begin
			c_next.open = 1'b1;
			c_next.pend = 1'b0;
		end
		if (rise) begin
			c_next.pend = 1'b1;
		end
		sw_off = c_reg.ccr[dma_chain_pkg::CCR_EN] && !c_next.ccr[dma_chain_pkg::CCR_EN];
		// ==================== channel control
		unique case (c_reg.st)
			dma_chain_pkg::CH_IDLE: begin
				// a link from the predecessor enables the channel
				start = (!c_reg.ccr[dma_chain_pkg::CCR_EN] && c_next.ccr[dma_chain_pkg::CCR_EN])
					|| link_enable_i;
				if (start) begin
					c_next.ccr[dma_chain_pkg::CCR_EN] = 1'b1;
					// frameless or unaligned enable reports misalignment
					if (c_reg.cen == '0 || c_reg.cfn == '0 || c_reg.src[1:0] != 2'b00
						|| c_reg.dst[1:0] != 2'b00) begin
						set_ev[dma_chain_pkg::EV_MISAL]    = 1'b1;
						c_next.ccr[dma_chain_pkg::CCR_EN] = 1'b0;
					end else begin
						c_next.st   = dma_chain_pkg::CH_RUN;
						c_next.rd_e = '0;
						c_next.rd_f = '0;
						c_next.wr_e = '0;
						c_next.wr_f = '0;
						c_next.rd_a = c_reg.src;
						c_next.wr_a = c_reg.dst;
						c_next.cnt  = '0;
						c_next.wp   = '0;
						c_next.rp   = '0;
						c_next.open = 1'b0;
						c_next.pend = rise;
					end
				end
			end
			dma_chain_pkg::CH_RUN: begin
				// disabled mid-transfer aborts unless it may drain
				if (sw_off) begin
					c_next.st = drain_cand ? dma_chain_pkg::CH_DRAIN : dma_chain_pkg::CH_ABORT;
				end
			end
			dma_chain_pkg::CH_DRAIN: begin
				if (!c_reg.rd_v && !c_reg.rd_w && !c_reg.wr_v && !c_reg.wr_w && c_reg.cnt == '0) begin
					c_next.st = dma_chain_pkg::CH_IDLE;
					c_next.ccr[dma_chain_pkg::CCR_EN] = 1'b0;
				end
			end
			dma_chain_pkg::CH_ABORT: begin
				// clean abort waits for outstanding answers, flushes, disables
				if (!c_reg.rd_v && !c_reg.rd_w && !c_reg.wr_v && !c_reg.wr_w) begin
					c_next.st = dma_chain_pkg::CH_IDLE;
					c_next.ccr[dma_chain_pkg::CCR_EN] = 1'b0;
					set_ev[dma_chain_pkg::EV_ABORT]   = 1'b1;
				end
			end
		endcase
		// ==================== read port
		if (c_reg.rd_v && rd_ready_i) begin
			c_next.rd_v = 1'b0;
			c_next.rd_w = 1'b1;
		end
		if (c_reg.rd_w && rd_rsp_valid_i) begin
			c_next.rd_w = 1'b0;
			if (rd_rsp_i.err) begin
				set_ev[dma_chain_pkg::EV_RDERR] = 1'b1;
				// read error aborts unless the channel may drain
				if (c_next.st == dma_chain_pkg::CH_RUN) begin
					c_next.st = drain_cand ? dma_chain_pkg::CH_DRAIN : dma_chain_pkg::CH_ABORT;
				end
			end else begin
				push        = 1'b1;
				c_next.rd_e = rstep[2*dma_chain_pkg::CW-1:dma_chain_pkg::CW];
				c_next.rd_f = rstep[dma_chain_pkg::CW-1:0];
				c_next.rd_a = c_reg.rd_a + dma_chain_pkg::ELEM_BYTES;
				if (src_side && rstep[dma_chain_pkg::CW-1:0] != c_reg.rd_f) begin
					c_next.open = 1'b0;
				end
			end
		end
		// ==================== write port
		if (c_reg.wr_v && wr_ready_i) begin
			c_next.wr_v = 1'b0;
			c_next.wr_w = 1'b1;
		end
		if (c_reg.wr_w && wr_rsp_valid_i) begin
			c_next.wr_w = 1'b0;
			if (wr_rsp_err_i) begin
				set_ev[dma_chain_pkg::EV_WRERR] = 1'b1;
			end
			if (wr_rsp_err_i && !w_last) begin
				// write error before block end goes to clean abort
				c_next.st = dma_chain_pkg::CH_ABORT;
			end else begin
				// counters move for data that was written and for an errored last element
				c_next.wr_e = wstep[2*dma_chain_pkg::CW-1:dma_chain_pkg::CW];
				c_next.wr_f = wstep[dma_chain_pkg::CW-1:0];
				c_next.wr_a = c_reg.wr_a + dma_chain_pkg::ELEM_BYTES;
				if (!src_side && wstep[dma_chain_pkg::CW-1:0] != c_reg.wr_f) begin
					c_next.open = 1'b0;
				end
				// block done when elements and frames are spent
				if (w_last) begin
					c_next.st   = dma_chain_pkg::CH_IDLE;
					c_next.link = c_reg.ccr[dma_chain_pkg::CCR_LINK];
					set_ev[dma_chain_pkg::EV_DONE] = 1'b1;
					// last-element error under destination-side or no-buffer hardware sync leaves enable for software to clear
					if (!(wr_rsp_err_i && !sw_sync && (!src_side || c_reg.ccr[dma_chain_pkg::CCR_NOBUF]))) begin
						c_next.ccr[dma_chain_pkg::CCR_EN] = 1'b0;
					end
				end
			end
		end
		// ==================== issue
		if (c_next.st == dma_chain_pkg::CH_RUN && !pause && !c_reg.rd_v && !c_reg.rd_w
			&& !rd_all && c_reg.cnt < dma_chain_pkg::DEPTH_CNT && rd_gate) begin
			c_next.rd_v = 1'b1;
		end
		// a write starts only with buffered data and all byte lanes set
		if ((c_next.st == dma_chain_pkg::CH_RUN || c_next.st == dma_chain_pkg::CH_DRAIN)
			&& !pause && !c_reg.wr_v && !c_reg.wr_w && !wr_all && c_reg.cnt != '0
			&& (wr_gate || c_next.st == dma_chain_pkg::CH_DRAIN)) begin
			pop         = 1'b1;
			c_next.wr_v = 1'b1;
			// burst marking follows the SDP burst bit on every start, linked or not
			c_next.wr_q = '{addr: c_reg.wr_a, data: buf_rdata, be: dma_chain_pkg::BE_ALL,
				burst: c_reg.sdp[dma_chain_pkg::SDP_BURST]};
		end
		if (push) begin
			c_next.wp = c_reg.wp + 3'h1;
		end
		if (pop) begin
			c_next.rp = c_reg.rp + 3'h1;
		end
		c_next.cnt = c_reg.cnt + dma_chain_pkg::CNT_W'(push) - dma_chain_pkg::CNT_W'(pop);
		// flush so buffer slots are recovered after abort
		if (set_ev[dma_chain_pkg::EV_ABORT]) begin
			c_next.cnt = '0;
			c_next.wp  = '0;
			c_next.rp  = '0;
		end
		// hardware set wins over a clear in the same cycle
		c_next.sts = (c_reg.sts & ~clr_ev) | set_ev;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			c_reg <= dma_chain_pkg::CH_RST;
			b_reg <= dma_chain_pkg::BUS_RST;
		end else begin
			c_reg <= c_next;
			b_reg <= b_next;
		end
	end

	// ==================== outputs
	assign awready_o     = !b_reg.awv && !b_reg.bv;
	assign wready_o      = !b_reg.wv && !b_reg.bv;
	assign bvalid_o      = b_reg.bv;
	assign bresp_o       = b_reg.br;
	assign arready_o     = !b_reg.rv;
	assign rvalid_o      = b_reg.rv;
	assign rdata_o       = b_reg.rd;
	assign rresp_o       = b_reg.rr;
	assign rd_valid_o    = c_reg.rd_v;
	assign rd_req_o.addr = c_reg.rd_a;
	assign wr_valid_o    = c_reg.wr_v;
	assign wr_req_o      = c_reg.wr_q;
	assign link_o        = c_reg.link;
	assign irq_o         = |(c_reg.sts & c_reg.ien);

	// ==================== checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_wr_mid_err;
		c_reg.wr_w && wr_rsp_valid_i && wr_rsp_err_i && !w_last;
	endsequence
	sequence s_abort_quiet;
		c_reg.st == dma_chain_pkg::CH_ABORT && !c_reg.rd_v && !c_reg.rd_w && !c_reg.wr_v && !c_reg.wr_w;
	endsequence

	chk_wr_err_abort: assert property (s_wr_mid_err |=> c_reg.st == dma_chain_pkg::CH_ABORT)
		else $error("write error did not start abort");
	chk_abort_ends: assert property (s_abort_quiet |=> c_reg.st == dma_chain_pkg::CH_IDLE
		&& !c_reg.ccr[dma_chain_pkg::CCR_EN] && c_reg.sts[dma_chain_pkg::EV_ABORT] && c_reg.cnt == '0)
		else $error("abort did not disable and flush");
	chk_off_abort: assert property (c_reg.st == dma_chain_pkg::CH_RUN && sw_off && !drain_cand
		&& !(c_reg.wr_w && wr_rsp_valid_i) |=> c_reg.st == dma_chain_pkg::CH_ABORT)
		else $error("disable without drain did not abort");
	chk_sw_read: assert property (c_reg.st == dma_chain_pkg::CH_RUN && sw_sync && !pause
		&& !c_reg.rd_v && !c_reg.rd_w && !rd_all && c_reg.cnt < dma_chain_pkg::DEPTH_CNT
		|=> rd_valid_o || c_reg.st != dma_chain_pkg::CH_RUN)
		else $error("software sync read not issued");
	chk_dst_gate: assert property ($rose(wr_valid_o) && !sw_sync && !src_side
		&& $past(c_reg.st) == dma_chain_pkg::CH_RUN |-> $past(c_reg.open))
		else $error("synchronized write without request");
	chk_burst_mark: assert property ($rose(wr_valid_o)
		|-> wr_req_o.burst == $past(c_reg.sdp[dma_chain_pkg::SDP_BURST]))
		else $error("burst marking lost");
	chk_link_start: assert property (c_reg.st == dma_chain_pkg::CH_IDLE && link_enable_i
		&& c_reg.cen != '0 && c_reg.cfn != '0 && c_reg.src[1:0] == 2'b00 && c_reg.dst[1:0] == 2'b00
		|=> c_reg.st == dma_chain_pkg::CH_RUN && c_reg.ccr[dma_chain_pkg::CCR_EN])
		else $error("link did not enable channel");
	chk_no_empty_wr: assert property ($rose(wr_valid_o)
		|-> $past(c_reg.cnt) != '0 && wr_req_o.be == dma_chain_pkg::BE_ALL)
		else $error("write started without data");
	chk_block_done: assert property (c_reg.wr_w && wr_rsp_valid_i && !wr_rsp_err_i && w_last
		|=> c_reg.st == dma_chain_pkg::CH_IDLE && c_reg.sts[dma_chain_pkg::EV_DONE])
		else $error("block end not flagged");
	chk_misalign: assert property (start && c_reg.cfn == '0
		|=> c_reg.sts[dma_chain_pkg::EV_MISAL] && c_reg.st == dma_chain_pkg::CH_IDLE)
		else $error("frameless enable not reported");
endmodule

// ===== dv/dma_port_model.sv
`timescale 1ns/1ps
// ==================== far-side read and write ports
module dma_port_model (
	input  wire logic                   mclk_i,
	input  wire logic                   clr_i,
	input  wire logic                   slow_i,
	input  wire logic [3:0]             err_at_i,
	input  wire logic                   rd_valid_i,
	output logic                        rd_ready_o,
	input  wire dma_chain_pkg::rd_req_t rd_req_i,
	output logic                        rd_rsp_valid_o,
	output dma_chain_pkg::rd_rsp_t      rd_rsp_o,
	input  wire logic                   wr_valid_i,
	output logic                        wr_ready_o,
	input  wire dma_chain_pkg::wr_req_t wr_req_i,
	output logic                        wr_rsp_valid_o,
	output logic                        wr_rsp_err_o,
	output logic [3:0]                  wr_n_o,
	output logic                        be_bad_o,
	output dma_chain_pkg::wr_req_t      wr_last_o
);
	logic go;
	assign rd_ready_o = rd_valid_i && go;
	assign wr_ready_o = wr_valid_i && go;
	always @(posedge mclk_i) begin
		go <= slow_i ? 1'($urandom % 2) : 1'b1;
		rd_rsp_valid_o <= rd_ready_o;
		// read data is the address; idle data toggles so stale words never look valid
		rd_rsp_o <= rd_ready_o ? {rd_req_i.addr, 1'b0} : ~rd_rsp_o;
		wr_rsp_valid_o <= wr_ready_o;
		wr_rsp_err_o <= wr_ready_o && wr_n_o == err_at_i;
		if (clr_i) begin
			wr_n_o <= 4'h0;
			be_bad_o <= 1'b0;
			rd_rsp_o <= '0;
		end else if (wr_ready_o) begin
			wr_n_o <= wr_n_o + 4'h1;
			wr_last_o <= wr_req_i;
			if (wr_req_i.be != 4'hF) be_bad_o <= 1'b1;
		end
	end
endmodule

// ===== dv/dma_chain_channel_test.sv
`timescale 1ns/1ps
module dma_chain_channel_test;
	logic        mclk_i = 0, rst_i = 1, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
	logic        arvalid_i = 0, rready_i = 0, preq = 0, lnk_en = 0, clr = 1, slow = 0;
	logic [7:0]  awaddr_i = '0, araddr_i = '0;
	logic [31:0] wdata_i = '0, rdata_o, rd_d;
	logic [3:0]  wr_n, err_at = 4'hF, strb = 4'hF;
	logic [1:0]  bresp_o, rresp_o, rd_r, wr_r;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o, link_o, be_bad;
	logic        rd_valid, rd_ready, rd_rsp_valid, wr_valid, wr_ready, wr_rsp_valid, wr_err;
	dma_chain_pkg::rd_req_t rd_req;
	dma_chain_pkg::rd_rsp_t rd_rsp;
	dma_chain_pkg::wr_req_t wr_req, wr_last;
	int          bad_count = 0, compares = 0, cyc = 0, links = 0, l0, e, f;
	logic        b;
	always #2.5 mclk_i = ~mclk_i;
	dma_chain_channel uut (.mclk_i(mclk_i), .rst_i(rst_i), .awvalid_i(awvalid_i),
		.awready_o(awready_o), .awaddr_i(awaddr_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
		.wdata_i(wdata_i), .wstrb_i(strb), .bvalid_o(bvalid_o), .bready_i(bready_i),
		.bresp_o(bresp_o), .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
		.rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
		.peripheral_request_i(preq), .link_enable_i(lnk_en), .link_o(link_o),
		.rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_req_o(rd_req),
		.rd_rsp_valid_i(rd_rsp_valid), .rd_rsp_i(rd_rsp), .wr_valid_o(wr_valid),
		.wr_ready_i(wr_ready), .wr_req_o(wr_req), .wr_rsp_valid_i(wr_rsp_valid),
		.wr_rsp_err_i(wr_err), .irq_o(irq_o));
	dma_port_model far (.mclk_i(mclk_i), .clr_i(clr), .slow_i(slow), .err_at_i(err_at),
		.rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .rd_req_i(rd_req),
		.rd_rsp_valid_o(rd_rsp_valid), .rd_rsp_o(rd_rsp), .wr_valid_i(wr_valid),
		.wr_ready_o(wr_ready), .wr_req_i(wr_req), .wr_rsp_valid_o(wr_rsp_valid),
		.wr_rsp_err_o(wr_err), .wr_n_o(wr_n), .be_bad_o(be_bad), .wr_last_o(wr_last));
	// ==================== timeout and link pulses
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (link_o === 1'b1) links <= links + 1;
		if (cyc == 30000) begin
			bad_count++;
			test_done;
		end
	end
	// ==================== helpers
	function automatic logic [31:0] exp_addr(input logic [31:0] base, input int n);
		return base + dma_chain_pkg::ELEM_BYTES * (n - 1);
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		@(posedge mclk_i);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1;
		wvalid_i <= 1;
		bready_i <= 1;
		hb = 0;
		// handshakes judged at the falling edge, acted on at the next rising edge
		while (!hb) begin
			@(negedge mclk_i);
			ha = awvalid_i & awready_o;
			hw = wvalid_i & wready_o;
			hb = bvalid_o;
			wr_r = bresp_o;
			@(posedge mclk_i);
			if (ha) awvalid_i <= 0;
			if (hw) wvalid_i <= 0;
		end
		bready_i <= 0;
	endtask
	task automatic axr(input logic [7:0] a);
		logic ha, hr;
		@(posedge mclk_i);
		araddr_i <= a;
		arvalid_i <= 1;
		rready_i <= 1;
		hr = 0;
		while (!hr) begin
			@(negedge mclk_i);
			ha = arvalid_i & arready_o;
			hr = rvalid_o;
			rd_d = rdata_o;
			rd_r = rresp_o;
			@(posedge mclk_i);
			if (ha) arvalid_i <= 0;
		end
		rready_i <= 0;
	endtask
	task automatic run(input int ne, nf, input logic [31:0] ccr, sdp, input logic lk,
		input logic [31:0] msk, sts);
		axw(dma_chain_pkg::OFS_CLR, 32'h1F);
		@(negedge mclk_i);
		chk("irq cleared", 0, irq_o);
		clr <= 1;
		axw(dma_chain_pkg::OFS_CEN, ne);
		axw(dma_chain_pkg::OFS_CFN, nf);
		axw(dma_chain_pkg::OFS_SRC, 32'h0000_1000);
		axw(dma_chain_pkg::OFS_DST, 32'h0000_2000);
		axw(dma_chain_pkg::OFS_SDP, sdp);
		clr <= 0;
		axw(dma_chain_pkg::OFS_CCR, ccr);
		lnk_en <= lk;
		preq <= ccr[0];
		@(posedge mclk_i);
		lnk_en <= 0;
		while (irq_o !== 1'b1) @(negedge mclk_i);
		preq <= 0;
		axr(dma_chain_pkg::OFS_CSR);
		while (rd_d[dma_chain_pkg::CSR_BUSY]) axr(dma_chain_pkg::OFS_CSR);
		chk("status", sts, rd_d & msk);
	endtask
	task automatic post(input int n, input logic bb);
		chk("write count", n, wr_n);
		chk("empty byte enables", 0, be_bad);
		chk("last dst", exp_addr(32'h0000_2000, n), wr_last.addr);
		chk("last data", exp_addr(32'h0000_1000, n), wr_last.data);
		chk("burst", bb, wr_last.burst);
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==================== tests
	initial begin
		void'($urandom(16));
		repeat (16) @(posedge mclk_i);
		rst_i <= 0;
		axr(dma_chain_pkg::OFS_CSR);
		chk("status reset", 0, rd_d);
		axr(8'h40);
		chk("unmapped resp", dma_chain_pkg::RESP_SLVERR, rd_r);
		axw(dma_chain_pkg::OFS_IEN, 32'h1F);
		axr(dma_chain_pkg::OFS_IEN);
		chk("irq enable", 32'h1F, rd_d);
		strb <= 4'h1;
		axw(dma_chain_pkg::OFS_SRC, 32'hFFFF_FFFF);
		strb <= 4'hF;
		axr(dma_chain_pkg::OFS_SRC);
		chk("strobe merge", 32'h0000_00FF, rd_d);
		axw(8'h40, 32'h0);
		chk("unmapped write resp", dma_chain_pkg::RESP_SLVERR, wr_r);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			e = 1 + $urandom % 4;
			f = 1 + $urandom % 2;
			b = 1'($urandom % 2);
			slow <= 1'($urandom % 2);
			l0 = links;
			run(e, f, 32'h0000_8080, 32'(b) << 14, 0, 32'h8099, 32'h1);
			post(e * f, b);
			chk("link pulse", l0 + 1, links);
		end
		$display("test software sync done");
		err_at <= 4'h1;
		run(4, 1, 32'h80, 0, 0, 32'h8088, 32'h08);
		chk("no empty write", 0, be_bad);
		$display("test write abort done");
		err_at <= 4'hF;
		// software recovery with zero frames
		run(1, 0, 32'h80, 0, 0, 32'h8090, 32'h10);
		$display("test recovery done");
		run(2, 1, 32'h0, 32'h4000, 1, 32'h8099, 32'h1);
		post(2, 1);
		$display("test link enable done");
		err_at <= 4'h1;
		run(2, 1, 32'h0080_0081, 0, 0, 32'h8085, 32'h85);
		post(2, 0);
		// software clears enable after write error
		axw(dma_chain_pkg::OFS_CCR, 32'h0);
		axr(dma_chain_pkg::OFS_CSR);
		chk("enable cleared", 0, rd_d & 32'h8080);
		axw(dma_chain_pkg::OFS_IEN, 32'h0);
		@(negedge mclk_i);
		chk("irq masked", 0, irq_o);
		axw(dma_chain_pkg::OFS_IEN, 32'h4);
		@(negedge mclk_i);
		chk("irq unmasked", 1, irq_o);
		$display("test last element error done");
		axw(dma_chain_pkg::OFS_CCR, 32'h81);
		axr(dma_chain_pkg::OFS_CSR);
		chk("stalled busy", 32'h8080, rd_d & 32'h8080);
		axw(dma_chain_pkg::OFS_CCR, 32'h01);
		axr(dma_chain_pkg::OFS_CSR);
		chk("disable abort", 32'h08, rd_d & 32'h8088);
		$display("test disable abort done");
		test_done;
	end
endmodule
